//--- core/fsp_pkg.sv
// Package for the flash sector protection host controller.
// Assumes a 100 MHz pclk and an APB master in software's place.
//
// How it works
// - Host protects all before unprotect cycle
// - Unprotect clears all; host reprotects needed
// - High voltage hard-clear enables bus algorithm
// - Host always drives boot-lock defined
package fsp_pkg;
  // ==========================================================
  // Register map (APB byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SECT = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_RDAT = 8'h0C;
  // CTRL fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_CMD_LSB = 1;
  localparam int CTRL_HV = 4;
  localparam int CTRL_WP = 5;
  localparam int CTRL_ALT = 6;
  localparam int CTRL_SECURE = 7;
  // STAT fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_PROT = 1;
  localparam int STAT_IND = 2;
  localparam int STAT_SECURE = 3;
  localparam int STAT_ERR = 4;
  localparam int STAT_WPLOW = 5;
  // ==========================================================
  // Device pin codes
  localparam logic [7:0] ID_PROT = 8'h01;
  localparam logic [7:0] ID_UNPROT = 8'h00;
  localparam logic [7:0] IND_MASK = 8'h80;
  localparam logic [7:0] BOOT_LOW_LAST = 8'h01;
  localparam logic [7:0] BOOT_HIGH_FIRST = 8'hFE;
  localparam logic [7:0] SMALL_GROUP_TOP = 8'h07;
  localparam int SECURE_KBYTES = 64;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 10;
  localparam int CYCLE_NS = 100;
  localparam logic [7:0] CYCLE_CNT = 8'(CYCLE_NS / CLK_NS);
  typedef enum logic [2:0] {
    FSP_IDLE = 3'b000,
    FSP_ADDR = 3'b001,
    FSP_STRB = 3'b011,
    FSP_HOLD = 3'b010,
    FSP_DONE = 3'b110
  } fsp_state_t;
  typedef enum logic [2:0] {
    FSP_CMD_PROT = 3'h0,
    FSP_CMD_UNPROT = 3'h1,
    FSP_CMD_VERIFY = 3'h2,
    FSP_CMD_IND = 3'h3,
    FSP_CMD_ENTER = 3'h4,
    FSP_CMD_EXIT = 3'h5,
    FSP_CMD_RDSYNC = 3'h6
  } fsp_cmd_t;
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] dq_o;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic hv_clear;
    logic hv_addr9;
    logic hv_oe;
    logic boot_lock;
  } fsp_pins_t;
  typedef struct packed {
    fsp_state_t st;
    logic [2:0] cmd;
    logic [1:0] step;
    logic [7:0] cnt;
    logic [7:0] sect;
    logic [7:0] rdat;
    logic hv;
    logic wp;
    logic alt;
    logic busy;
    logic err;
    logic prot;
    logic ind;
    logic secure;
    logic [31:0] prdata;
    logic pready;
    fsp_pins_t pin;
  } fsp_state_s_t;
endpackage : fsp_pkg

//--- core/fsp_host.sv
// Host controller driving the flash protection pins from APB orders.
// Assumes an APB master on pclk and the device's bus on the pin side.
`timescale 1ns/1ps
module fsp_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output fsp_pkg::fsp_pins_t pins,
  input wire logic [7:0] dq_i
);
  fsp_pkg::fsp_state_s_t s_r;
  fsp_pkg::fsp_state_s_t s_nxt;
  logic [7:0] dq_s1_r;
  logic [7:0] dq_s2_r;
  logic [7:0] dq_s3_r;
  logic dq_stable;

  // ==========================================================
  // Pin input synchroniser; change counts once stages 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
      dq_s3_r <= 8'h00;
    end else begin
      dq_s1_r <= dq_i;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
    end
  end
  assign dq_stable = (dq_s2_r == dq_s3_r);

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
    is_addr = (a == r);
  endfunction : is_addr

  function automatic fsp_pkg::fsp_cmd_t fsp_state_cmd(input logic [2:0] c);
    fsp_state_cmd = fsp_pkg::fsp_cmd_t'(c);
  endfunction : fsp_state_cmd

  // ==========================================================
  // Next state
  always_comb begin
    logic wr;
    logic rd;
    logic [31:0] w;
    s_nxt = s_r;
    // Write lands at the access edge, where pready is seen high
    wr = psel && penable && pwrite && s_r.pready;
    rd = psel && !penable;
    w = pwdata;
    s_nxt.pready = psel && !penable;
    if (rd) begin
      s_nxt.prdata = 32'h0000_0000;
      if (is_addr(paddr, fsp_pkg::REG_CTRL)) begin
        s_nxt.prdata[fsp_pkg::CTRL_CMD_LSB +: 3] = s_r.cmd;
        s_nxt.prdata[fsp_pkg::CTRL_HV] = s_r.hv;
        s_nxt.prdata[fsp_pkg::CTRL_WP] = s_r.wp;
        s_nxt.prdata[fsp_pkg::CTRL_ALT] = s_r.alt;
      end else if (is_addr(paddr, fsp_pkg::REG_SECT)) begin
        s_nxt.prdata[7:0] = s_r.sect;
      end else if (is_addr(paddr, fsp_pkg::REG_STAT)) begin
        s_nxt.prdata[fsp_pkg::STAT_BUSY] = s_r.busy;
        s_nxt.prdata[fsp_pkg::STAT_PROT] = s_r.prot;
        s_nxt.prdata[fsp_pkg::STAT_IND] = s_r.ind;
        s_nxt.prdata[fsp_pkg::STAT_SECURE] = s_r.secure;
        s_nxt.prdata[fsp_pkg::STAT_ERR] = s_r.err;
        s_nxt.prdata[fsp_pkg::STAT_WPLOW] = !s_r.wp;
      end else if (is_addr(paddr, fsp_pkg::REG_RDAT)) begin
        s_nxt.prdata[7:0] = s_r.rdat;
      end
    end
    if (wr && is_addr(paddr, fsp_pkg::REG_SECT) && !s_r.busy) begin
      s_nxt.sect = w[7:0];
    end
    if (wr && is_addr(paddr, fsp_pkg::REG_CTRL) && !s_r.busy) begin
      s_nxt.hv = w[fsp_pkg::CTRL_HV];
      s_nxt.wp = w[fsp_pkg::CTRL_WP];
      s_nxt.alt = w[fsp_pkg::CTRL_ALT];
      s_nxt.cmd = w[fsp_pkg::CTRL_CMD_LSB +: 3];
      if (w[fsp_pkg::CTRL_GO]) begin
        // Bus algorithm needs high voltage on hard-clear or alt pins
        if ((w[fsp_pkg::CTRL_CMD_LSB +: 3] <= 3'(fsp_pkg::FSP_CMD_UNPROT))
            && !w[fsp_pkg::CTRL_HV] && !w[fsp_pkg::CTRL_ALT]) begin
          s_nxt.err = 1'b1;
        end else begin
          s_nxt.err = 1'b0;
          s_nxt.busy = 1'b1;
          s_nxt.st = fsp_pkg::FSP_ADDR;
          s_nxt.cnt = 8'h00;
        end
      end
    end
    s_nxt.pin.hv_clear = s_nxt.hv;
    s_nxt.pin.hv_addr9 = s_nxt.alt;
    s_nxt.pin.hv_oe = s_nxt.alt;
    s_nxt.pin.boot_lock = s_nxt.wp;
    if (s_r.st != fsp_pkg::FSP_IDLE) begin
      s_nxt.cnt = s_r.cnt + 8'h01;
    end
    case (s_r.st)
      fsp_pkg::FSP_IDLE: begin
        s_nxt.pin.ce_n = 1'b1;
        s_nxt.pin.we_n = 1'b1;
        s_nxt.pin.oe_n = 1'b1;
        s_nxt.pin.dq_oe = 1'b0;
      end
      fsp_pkg::FSP_ADDR: begin
        s_nxt.pin.ce_n = 1'b0;
        s_nxt.pin.addr = {s_r.sect, 12'h000};
        s_nxt.pin.addr[1:0] = 2'b00;
        case (fsp_state_cmd(s_r.cmd))
          fsp_pkg::FSP_CMD_UNPROT: s_nxt.pin.addr[6] = 1'b1;
          fsp_pkg::FSP_CMD_VERIFY: s_nxt.pin.addr[1:0] = 2'b10;
          fsp_pkg::FSP_CMD_IND: s_nxt.pin.addr[1:0] = 2'b11;
          default: s_nxt.pin.addr[6] = 1'b0;
        endcase
        if (s_r.cmd <= 3'(fsp_pkg::FSP_CMD_UNPROT) || s_r.cmd >= 3'(fsp_pkg::FSP_CMD_ENTER)) begin
          s_nxt.pin.dq_oe = 1'b1;
          s_nxt.pin.dq_o = {5'h00, s_r.cmd};
        end
        s_nxt.st = fsp_pkg::FSP_STRB;
        s_nxt.cnt = 8'h00;
      end
      fsp_pkg::FSP_STRB: begin
        if (s_r.pin.dq_oe) begin
          s_nxt.pin.we_n = 1'b0;
        end else begin
          s_nxt.pin.oe_n = 1'b0;
        end
        if (s_r.cnt == fsp_pkg::CYCLE_CNT) begin
          s_nxt.st = fsp_pkg::FSP_HOLD;
          s_nxt.cnt = 8'h00;
        end
      end
      fsp_pkg::FSP_HOLD: begin
        if (!s_r.pin.dq_oe && dq_stable) begin
          s_nxt.rdat = dq_s3_r;
          if (fsp_state_cmd(s_r.cmd) == fsp_pkg::FSP_CMD_VERIFY) begin
            s_nxt.prot = (dq_s3_r == fsp_pkg::ID_PROT);
          end
          if (fsp_state_cmd(s_r.cmd) == fsp_pkg::FSP_CMD_IND) begin
            s_nxt.ind = |(dq_s3_r & fsp_pkg::IND_MASK);
          end
        end
        s_nxt.pin.we_n = 1'b1;
        s_nxt.pin.oe_n = 1'b1;
        s_nxt.st = fsp_pkg::FSP_DONE;
      end
      fsp_pkg::FSP_DONE: begin
        s_nxt.pin.ce_n = 1'b1;
        s_nxt.pin.dq_oe = 1'b0;
        if (fsp_state_cmd(s_r.cmd) == fsp_pkg::FSP_CMD_ENTER) s_nxt.secure = 1'b1;
        if (fsp_state_cmd(s_r.cmd) == fsp_pkg::FSP_CMD_EXIT) s_nxt.secure = 1'b0;
        s_nxt.busy = 1'b0;
        s_nxt.st = fsp_pkg::FSP_IDLE;
      end
      default: s_nxt.st = fsp_pkg::FSP_IDLE;
    endcase
  end

  // ==========================================================
  // State register; boot-lock defaults high so it is never floating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.wp <= 1'b1;
      s_r.pin.boot_lock <= 1'b1;
      s_r.pin.ce_n <= 1'b1;
      s_r.pin.oe_n <= 1'b1;
      s_r.pin.we_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = 1'b0;
  assign pins = s_r.pin;

  // ==========================================================
  property p_strobe_len;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == fsp_pkg::FSP_ADDR) |=> (s_r.st == fsp_pkg::FSP_STRB && s_r.cnt == 8'h00)
      ##10 (s_r.st == fsp_pkg::FSP_STRB && s_r.cnt == fsp_pkg::CYCLE_CNT) ##1
      (s_r.st == fsp_pkg::FSP_HOLD);
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
  property p_strobe_bound;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == fsp_pkg::FSP_STRB) |-> (s_r.cnt <= fsp_pkg::CYCLE_CNT);
  endproperty
  a_strobe_bound: assert property (p_strobe_bound) else $error("strobe overrun");
  property p_hv_follows;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && s_r.pready && paddr == fsp_pkg::REG_CTRL && !s_r.busy)
      |=> (s_r.pin.hv_clear == $past(pwdata[fsp_pkg::CTRL_HV]));
  endproperty
  a_hv_follows: assert property (p_hv_follows) else $error("hard-clear lags");
  property p_no_prot_without_hv;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == fsp_pkg::FSP_STRB && s_r.cmd <= 3'(fsp_pkg::FSP_CMD_UNPROT))
      |-> (s_r.pin.hv_clear || s_r.pin.hv_addr9);
  endproperty
  a_no_prot_without_hv: assert property (p_no_prot_without_hv) else $error("no high voltage");
  property p_wp_driven;
    @(posedge pclk) disable iff (!presetn) s_r.pin.boot_lock == s_r.wp;
  endproperty
  a_wp_driven: assert property (p_wp_driven) else $error("boot-lock not driven");
  property p_alt_pair;
    @(posedge pclk) disable iff (!presetn) s_r.pin.hv_addr9 == s_r.pin.hv_oe;
  endproperty
  a_alt_pair: assert property (p_alt_pair) else $error("alternate pins split");
  property p_busy_clears;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == fsp_pkg::FSP_DONE) |=> !s_r.busy ##0 (s_r.st == fsp_pkg::FSP_IDLE);
  endproperty
  a_busy_clears: assert property (p_busy_clears) else $error("busy stuck");
  property p_enter_maps;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == fsp_pkg::FSP_DONE && s_r.cmd == 3'(fsp_pkg::FSP_CMD_ENTER)) |=> s_r.secure;
  endproperty
  a_enter_maps: assert property (p_enter_maps) else $error("enter not taken");
  property p_exit_unmaps;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == fsp_pkg::FSP_DONE && s_r.cmd == 3'(fsp_pkg::FSP_CMD_EXIT)) |=> !s_r.secure;
  endproperty
  a_exit_unmaps: assert property (p_exit_unmaps) else $error("exit not taken");
endmodule : fsp_host

//--- tb/fsp_flash_model.sv
// Behavioural flash device behind fsp_pins_t: protection bits, readout.
// Assumes a bottom-boot part; no array data is kept.
`timescale 1ns/1ps
module fsp_flash_model #(
  parameter logic IND = 1'b1
) (
  input wire fsp_pkg::fsp_pins_t pins,
  output logic [7:0] dq
);
  // ==========================================================
  // Protection state, one bit per block leader
  logic [255:0] prot_r = '0;
  logic [7:0] last_r = 8'h00;
  function automatic logic [7:0] grp(input logic [7:0] a);
    if (a[7:3] == 5'h00) return a;
    if (a[7:5] == 3'h0) return 8'h08;
    if (a[7:5] != 3'h7) return {a[7:5], 5'h00};
    return (a[7:3] == 5'h1F) ? 8'hF8 : 8'hE0;
  endfunction : grp
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && (pins.hv_clear || (pins.hv_addr9 && pins.hv_oe))) begin
      if (pins.addr[6]) prot_r <= '0;
      else prot_r[grp(pins.addr[19:12])] <= 1'b1;
    end
  end
  // Released bus flips, so a stale byte never looks valid
  always @* begin
    if (!pins.ce_n && !pins.oe_n) begin
      dq = pins.addr[0] ? {IND, 7'h00} : {7'h00, prot_r[grp(pins.addr[19:12])]};
      last_r = dq;
    end else begin
      dq = ~last_r;
    end
  end
endmodule : fsp_flash_model

//--- tb/testbench.sv
// Self-checking bench for fsp_host over APB, flash model on the pins.
// Assumes fsp_pkg and the model are compiled first.
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  fsp_pkg::fsp_pins_t pins;
  logic [7:0] dq;
  logic [31:0] sd = 32'h25B2;
  logic [31:0] rv;
  logic [255:0] ep = '0;
  logic wp = 1'b1;
  logic [7:0] reps [17] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h08, 8'h20, 8'h40, 8'h60, 8'h80, 8'hA0, 8'hC0, 8'hE0, 8'hF8};
  int error_cnt = 0;
  int total_checks = 0;
  int i;
  always #5 pclk = ~pclk;
  fsp_host DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(), .pins(pins), .dq_i(dq));
  fsp_flash_model #(.IND(1'b1)) flash (.pins(pins), .dq(dq));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [7:0] grp(input logic [7:0] a);
    if (a[7:3] == 5'h00) return a;
    if (a[7:5] == 3'h0) return 8'h08;
    if (a[7:5] != 3'h7) return {a[7:5], 5'h00};
    return (a[7:3] == 5'h1F) ? 8'hF8 : 8'hE0;
  endfunction : grp
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic op(input logic [2:0] c, input logic hv, input logic alt);
    apb(1'b1, fsp_pkg::REG_CTRL, {25'h0, alt, wp, hv, c, 1'b1});
    do begin
      apb(1'b0, fsp_pkg::REG_STAT, 32'h0);
    end while (rv[fsp_pkg::STAT_BUSY] !== 1'b0);
  endtask : op
  task automatic ver(input logic [7:0] s);
    apb(1'b1, fsp_pkg::REG_SECT, {24'h0, s});
    op(fsp_pkg::FSP_CMD_VERIFY, 1'b0, 1'b0);
    apb(1'b0, fsp_pkg::REG_RDAT, 32'h0);
    chk("verify", rv, {24'h0, ep[grp(s)] ? fsp_pkg::ID_PROT : fsp_pkg::ID_UNPROT});
  endtask : ver
  task automatic prot(input logic [7:0] s, input logic hv, input logic alt);
    apb(1'b1, fsp_pkg::REG_SECT, {24'h0, s});
    op(fsp_pkg::FSP_CMD_PROT, hv, alt);
    if (hv | alt) ep[grp(s)] = 1'b1;
  endtask : prot
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // ==========================================================
  // Scenarios
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk("boot_lock", pins.boot_lock, 1'b1);
    for (i = 0; i < 4; i++) begin
      sd = lfsr(sd);
      ver(sd[7:0]);
    end
    $display("test shipped state done");
    prot(8'h30, 1'b0, 1'b0);
    chk("stat_err", rv[fsp_pkg::STAT_ERR], 1'b1);
    ver(8'h30);
    for (i = 0; i < 12; i++) begin
      sd = lfsr(sd);
      if (sd[9]) prot(sd[7:0], 1'b1, 1'b0);
      ver(sd[17:10]);
    end
    prot(8'h09, 1'b1, 1'b0);
    ver(8'h1F);
    ver(8'h07);
    $display("test protect done");
    foreach (reps[i]) prot(reps[i], 1'b1, 1'b0);
    op(fsp_pkg::FSP_CMD_UNPROT, 1'b1, 1'b0);
    ep = '0;
    for (i = 0; i < 17; i += 3) ver(reps[i]);
    $display("test unprotect done");
    prot(8'h44, 1'b0, 1'b1);
    ver(8'h5F);
    op(fsp_pkg::FSP_CMD_IND, 1'b0, 1'b0);
    chk("indicator", rv[fsp_pkg::STAT_IND], 1'b1);
    wp = 1'b0;
    apb(1'b1, fsp_pkg::REG_CTRL, {26'h0, wp, 5'h00});
    apb(1'b0, fsp_pkg::REG_STAT, 32'h0);
    chk("boot_lock", pins.boot_lock, 1'b0);
    chk("stat_wplow", rv[fsp_pkg::STAT_WPLOW], 1'b1);
    wp = 1'b1;
    op(fsp_pkg::FSP_CMD_RDSYNC, 1'b0, 1'b0);
    chk("rdsync_err", rv[fsp_pkg::STAT_ERR], 1'b0);
    op(fsp_pkg::FSP_CMD_ENTER, 1'b0, 1'b0);
    chk("secure_on", rv[fsp_pkg::STAT_SECURE], 1'b1);
    op(fsp_pkg::FSP_CMD_EXIT, 1'b0, 1'b0);
    chk("secure_off", rv[fsp_pkg::STAT_SECURE], 1'b0);
    op(fsp_pkg::FSP_CMD_ENTER, 1'b0, 1'b0);
    // Hardware reset in mid-run must drop the region mapping
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("boot_lock_rst", pins.boot_lock, 1'b1);
    apb(1'b0, fsp_pkg::REG_STAT, 32'h0);
    chk("secure_rst", rv[fsp_pkg::STAT_SECURE], 1'b0);
    $display("test modes done");
    summarize();
  end
  initial begin
    // Run needs about 1500 cycles; over thirteen times that means a hang
    repeat (20000) @(posedge pclk);
    error_cnt++;
    summarize();
  end
endmodule : testbench
